// ### fuse_bank_pkg.sv
// constants, types and field layout of the program-once configuration bank
// assumes a single clock domain and word-indexed register access
package fuse_bank_pkg;

    localparam int WORD_W = 24;
    localparam int ADDR_W = 4;
    localparam int NUM_FUSE = 7;

    // word indices on the register port
    localparam logic [ADDR_W-1:0] POWER_ON_IDX = 4'h0;
    localparam logic [ADDR_W-1:0] DEBUG_IDX = 4'h1;
    localparam logic [ADDR_W-1:0] IVL_LOW_IDX = 4'h2;
    localparam logic [ADDR_W-1:0] IVL_HIGH_IDX = 4'h3;
    localparam logic [ADDR_W-1:0] CNT_LOW_IDX = 4'h4;
    localparam logic [ADDR_W-1:0] CNT_HIGH_IDX = 4'h5;
    localparam logic [ADDR_W-1:0] DEADMAN_OPT_IDX = 4'h6;
    localparam logic [ADDR_W-1:0] STATUS_IDX = 4'h7;
    localparam logic [ADDR_W-1:0] CONTROL_IDX = 4'h8;
    localparam logic [ADDR_W-1:0] FUSE_COUNT = 4'h7;

    // erased value of every fuse word
    localparam logic [WORD_W-1:0] ERASED_WORD = 24'hffffff;

    // programmable positions per word, reserved bits included
    localparam logic [WORD_W-1:0] POWER_ON_MASK = 24'h000470;
    localparam logic [WORD_W-1:0] DEBUG_MASK = 24'h0080a3;
    localparam logic [WORD_W-1:0] HALF_MASK = 24'h00ffff;
    localparam logic [WORD_W-1:0] DEADMAN_OPT_MASK = 24'h000001;
    localparam logic [NUM_FUSE-1:0][WORD_W-1:0] PROG_MASK = {
        DEADMAN_OPT_MASK, HALF_MASK, HALF_MASK, HALF_MASK, HALF_MASK,
        DEBUG_MASK, POWER_ON_MASK};

    // field positions
    localparam int SELFTEST_DIS_BIT = 6;
    localparam int BOOT_SWAP_DIS_BIT = 15;
    localparam int SCAN_EN_BIT = 5;
    localparam int DBG_SEL_LSB = 0;
    localparam int DEADMAN_DIS_BIT = 0;
    localparam int HALF_W = 16;

    // debugger channel codes
    localparam logic [1:0] DBG_PAIR_ONE = 2'h3;
    localparam logic [1:0] DBG_PAIR_TWO = 2'h2;
    localparam logic [1:0] DBG_PAIR_THREE = 2'h1;

    // status and control bits
    localparam int STAT_LOADED_BIT = 0;
    localparam int STAT_POR_BIT = 1;
    localparam int STAT_SELFTEST_BIT = 2;
    localparam int STAT_LOCK_BIT = 3;
    localparam int CTRL_LOCK_BIT = 0;

    typedef enum logic [2:0] {
        ST_LOAD = 3'h1,
        ST_SETTLE = 3'h2,
        ST_RUN = 3'h4
    } load_state_t;

    typedef struct packed {
        logic boot_swap_instr_disable;
        logic scan_port_enable;
        logic [2:0] debug_pair_sel;
        logic deadman_enable;
        logic [31:0] deadman_window_interval;
        logic [31:0] deadman_instr_count_limit;
    } cfg_out_t;

endpackage

// ### pin_sync.sv
// three-stage synchroniser with agreement filter for an asynchronous level
// assumes the level is held for several clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic pin_in, // asynchronous level
    output logic level_out // filtered level
);
    logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

    // a change counts only once the second and third stages agree
    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s2_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule
`default_nettype wire

// ### fuse_store.sv
// nonvolatile program-once word store with registered read ports
// assumes erase_n is only pulsed to model a factory-erased array
`timescale 1ns/1ps
`default_nettype none
module fuse_store (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // reset for read registers, active low
    input wire logic erase_n, // array erase to all ones, active low
    input wire logic prog_en, // program one word this cycle
    input wire logic [3:0] prog_idx, // word to program
    input wire logic [23:0] prog_data, // zeros clear bits
    input wire logic bus_rd, // register read strobe
    input wire logic [3:0] bus_idx, // register read index
    input wire logic side_sel, // answer with side_word instead
    input wire logic [23:0] side_word, // word from block state
    output logic [23:0] bus_rdata, // read answer, one cycle later
    input wire logic [3:0] load_idx, // loader read index
    output logic [23:0] load_rdata // loader answer, one cycle later
);
    logic [fuse_bank_pkg::NUM_FUSE-1:0][23:0] mem_q, mem_d;
    logic [23:0] rd_q, rd_d, ld_q, ld_d;

    // bits only go from one to zero; unprogrammable bits stay one
    genvar i;
    generate
        for (i = 0; i < fuse_bank_pkg::NUM_FUSE; i++) begin : g_word
            always_comb begin
                mem_d[i] = mem_q[i];
                if (prog_en && prog_idx == 4'(i)) begin
                    mem_d[i] = mem_q[i] & (prog_data | ~fuse_bank_pkg::PROG_MASK[i]);
                end
            end
        end
    endgenerate

    // bus read data stand only in the cycle after the strobe; loader data follow load_idx every cycle
    always_comb begin
        rd_d = 24'h000000;
        ld_d = 24'h000000;
        if (bus_rd) begin
            if (side_sel) begin
                rd_d = side_word;
            end else if (bus_idx < fuse_bank_pkg::FUSE_COUNT) begin
                rd_d = mem_q[bus_idx[2:0]];
            end
        end
        if (load_idx < fuse_bank_pkg::FUSE_COUNT) begin
            ld_d = mem_q[load_idx[2:0]];
        end
    end

    // array survives rst_n; only the erase input restores it
    always_ff @(posedge clk_sys or negedge erase_n) begin
        if (!erase_n) begin
            mem_q <= {fuse_bank_pkg::NUM_FUSE{fuse_bank_pkg::ERASED_WORD}};
        end else begin
            mem_q <= mem_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 24'h000000;
            ld_q <= 24'h000000;
        end else begin
            rd_q <= rd_d;
            ld_q <= ld_d;
        end
    end

    assign bus_rdata = rd_q;
    assign load_rdata = ld_q;
endmodule
`default_nettype wire

// ### device_config_fuse_bank.sv
// configuration fuse bank: store, shadow loader, decode and register port
// assumes por_cause is held by the reset controller across rst_n release
// and that consumer units stay in reset until units_release rises
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - self-test disable bit skips reset self-test
// - self-test decision only after power-on reset
// - unimplemented bits and upper byte read one
// - boot-swap disable bit refuses boot-swap instruction
// - scan port works only when enabled
// - debugger channel code picks programming pin pair
// - window interval low half from low word
// - window interval high half from high word
// - count limit low half from low word
// - count limit high half from high word
// - bits readable, program-once, erased read one
// - deadman timer disabled when disable bit set
module device_config_fuse_bank (
    input wire logic clk_sys, // system clock, 200 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic erase_n, // factory erase of the store, active low
    input wire logic por_cause, // reset was power-on, asynchronous level
    input wire logic [3:0] bus_addr, // register word index
    input wire logic [23:0] bus_wdata, // register write data
    input wire logic bus_wr, // write strobe
    input wire logic bus_rd, // read strobe
    output logic [23:0] bus_rdata, // read data, cycle after strobe
    input wire logic boot_swap_req, // processor decodes a boot-swap
    output logic boot_swap_grant, // boot-swap may execute, pulse
    output logic boot_swap_refuse, // boot-swap refused, pulse
    output logic units_release, // shadows valid, consumers may run
    output logic selftest_start, // start memory self-test, pulse
    output fuse_bank_pkg::cfg_out_t cfg // decoded configuration
);
    fuse_bank_pkg::load_state_t state_q, state_d;
    logic [3:0] load_cnt_q, load_cnt_d;
    logic [fuse_bank_pkg::NUM_FUSE-1:0][23:0] shadow_q, shadow_d;
    logic [23:0] load_rdata;
    logic por_level;

    fuse_bank_pkg::cfg_out_t cfg_q, cfg_d;
    logic release_q, release_d;
    logic selftest_q, selftest_d;
    logic selftest_ran_q, selftest_ran_d;
    logic por_seen_q, por_seen_d;
    logic grant_q, grant_d;
    logic refuse_q, refuse_d;
    logic lock_q, lock_d;

    logic prog_en;
    logic side_sel;
    logic [23:0] side_word;
    logic [23:0] status_word;
    logic [23:0] control_word;

    pin_sync u_por_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(por_cause),
        .level_out(por_level)
    );

    // programming is refused once software sets the lock
    assign prog_en = bus_wr && !lock_q && (bus_addr < fuse_bank_pkg::FUSE_COUNT);

    // status and control words answer through the store's read register
    always_comb begin
        status_word = 24'h000000;
        status_word[fuse_bank_pkg::STAT_LOADED_BIT] = release_q;
        status_word[fuse_bank_pkg::STAT_POR_BIT] = por_seen_q;
        status_word[fuse_bank_pkg::STAT_SELFTEST_BIT] = selftest_ran_q;
        status_word[fuse_bank_pkg::STAT_LOCK_BIT] = lock_q;
        control_word = 24'h000000;
        control_word[fuse_bank_pkg::CTRL_LOCK_BIT] = lock_q;
        side_sel = (bus_addr == fuse_bank_pkg::STATUS_IDX) ||
            (bus_addr == fuse_bank_pkg::CONTROL_IDX);
        side_word = (bus_addr == fuse_bank_pkg::STATUS_IDX) ? status_word : control_word;
    end

    fuse_store u_store (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .erase_n(erase_n),
        .prog_en(prog_en),
        .prog_idx(bus_addr),
        .prog_data(bus_wdata),
        .bus_rd(bus_rd),
        .bus_idx(bus_addr),
        .side_sel(side_sel),
        .side_word(side_word),
        .bus_rdata(bus_rdata),
        .load_idx(load_cnt_q),
        .load_rdata(load_rdata)
    );

    // lock is set-only; it clears only with rst_n
    always_comb begin
        lock_d = lock_q;
        if (bus_wr && bus_addr == fuse_bank_pkg::CONTROL_IDX &&
            bus_wdata[fuse_bank_pkg::CTRL_LOCK_BIT]) begin
            lock_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_d;
        end
    end

    // loader walks the store one word a cycle; read data lag the index by one,
    // so word k lands while the counter shows k+1
    always_comb begin
        state_d = state_q;
        load_cnt_d = load_cnt_q;
        shadow_d = shadow_q;
        case (state_q)
            fuse_bank_pkg::ST_LOAD: begin
                if (load_cnt_q != 4'h0) begin
                    shadow_d[load_cnt_q[2:0] - 3'h1] = load_rdata;
                end
                if (load_cnt_q == fuse_bank_pkg::FUSE_COUNT) begin
                    state_d = fuse_bank_pkg::ST_SETTLE;
                end else begin
                    load_cnt_d = load_cnt_q + 4'h1;
                end
            end
            fuse_bank_pkg::ST_SETTLE: begin
                state_d = fuse_bank_pkg::ST_RUN;
            end
            fuse_bank_pkg::ST_RUN: begin
                // shadows frozen: later programming acts only after reset
                state_d = fuse_bank_pkg::ST_RUN;
            end
            default: begin
                state_d = fuse_bank_pkg::ST_LOAD;
                load_cnt_d = 4'h0;
            end
        endcase
    end

    // shadows reset to the erased value so an early look sees the safe side
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= fuse_bank_pkg::ST_LOAD;
            load_cnt_q <= 4'h0;
            shadow_q <= {fuse_bank_pkg::NUM_FUSE{fuse_bank_pkg::ERASED_WORD}};
        end else begin
            state_q <= state_d;
            load_cnt_q <= load_cnt_d;
            shadow_q <= shadow_d;
        end
    end

    // decode once, in the settle cycle, then hold until reset
    always_comb begin
        cfg_d = cfg_q;
        release_d = release_q;
        selftest_d = 1'b0;
        selftest_ran_d = selftest_ran_q;
        por_seen_d = por_seen_q;
        if (state_q == fuse_bank_pkg::ST_SETTLE) begin
            release_d = 1'b1;
            por_seen_d = por_level;
            cfg_d.boot_swap_instr_disable =
                shadow_q[fuse_bank_pkg::DEBUG_IDX][fuse_bank_pkg::BOOT_SWAP_DIS_BIT];
            cfg_d.scan_port_enable =
                shadow_q[fuse_bank_pkg::DEBUG_IDX][fuse_bank_pkg::SCAN_EN_BIT];
            case (shadow_q[fuse_bank_pkg::DEBUG_IDX][fuse_bank_pkg::DBG_SEL_LSB +: 2])
                fuse_bank_pkg::DBG_PAIR_ONE: cfg_d.debug_pair_sel = 3'h1;
                fuse_bank_pkg::DBG_PAIR_TWO: cfg_d.debug_pair_sel = 3'h2;
                fuse_bank_pkg::DBG_PAIR_THREE: cfg_d.debug_pair_sel = 3'h4;
                default: cfg_d.debug_pair_sel = 3'h0;
            endcase
            cfg_d.deadman_enable =
                !shadow_q[fuse_bank_pkg::DEADMAN_OPT_IDX][fuse_bank_pkg::DEADMAN_DIS_BIT];
            cfg_d.deadman_window_interval = {
                shadow_q[fuse_bank_pkg::IVL_HIGH_IDX][fuse_bank_pkg::HALF_W-1:0],
                shadow_q[fuse_bank_pkg::IVL_LOW_IDX][fuse_bank_pkg::HALF_W-1:0]};
            cfg_d.deadman_instr_count_limit = {
                shadow_q[fuse_bank_pkg::CNT_HIGH_IDX][fuse_bank_pkg::HALF_W-1:0],
                shadow_q[fuse_bank_pkg::CNT_LOW_IDX][fuse_bank_pkg::HALF_W-1:0]};
            // warm resets never start the self-test through this bit
            if (por_level &&
                !shadow_q[fuse_bank_pkg::POWER_ON_IDX][fuse_bank_pkg::SELFTEST_DIS_BIT]) begin
                selftest_d = 1'b1;
                selftest_ran_d = 1'b1;
            end
        end
    end

    // outputs idle at the safe side until the shadows are decoded
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '0;
            release_q <= 1'b0;
            selftest_q <= 1'b0;
            selftest_ran_q <= 1'b0;
            por_seen_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            release_q <= release_d;
            selftest_q <= selftest_d;
            selftest_ran_q <= selftest_ran_d;
            por_seen_q <= por_seen_d;
        end
    end

    // boot-swap answer one cycle after the request; refused before release
    always_comb begin
        grant_d = 1'b0;
        refuse_d = 1'b0;
        if (boot_swap_req) begin
            if (release_q && !cfg_q.boot_swap_instr_disable) begin
                grant_d = 1'b1;
            end else begin
                refuse_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            grant_q <= 1'b0;
            refuse_q <= 1'b0;
        end else begin
            grant_q <= grant_d;
            refuse_q <= refuse_d;
        end
    end

    assign boot_swap_grant = grant_q;
    assign boot_swap_refuse = refuse_q;
    assign units_release = release_q;
    assign selftest_start = selftest_q;
    assign cfg = cfg_q;
endmodule
`default_nettype wire

// ### fuse_bank_asserts.sv
// assertion checker for the configuration fuse bank, bound to its top module
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module fuse_bank_asserts (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic por_cause, // power-on cause level
    input wire logic [3:0] bus_addr, // word index
    input wire logic bus_rd, // read strobe
    input wire logic [23:0] bus_rdata, // read data
    input wire logic boot_swap_req, // boot-swap request
    input wire logic boot_swap_grant, // boot-swap granted
    input wire logic boot_swap_refuse, // boot-swap refused
    input wire logic units_release, // shadows valid
    input wire logic selftest_start, // self-test start pulse
    input wire fuse_bank_pkg::cfg_out_t cfg // decoded configuration
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // request steps shared by the boot-swap properties
    sequence s_swap_live;
        boot_swap_req && units_release;
    endsequence
    sequence s_swap_early;
        boot_swap_req && !units_release;
    endsequence

    chk_fill_ones: assert property (
        bus_rd && bus_addr < fuse_bank_pkg::FUSE_COUNT |=>
        (bus_rdata | fuse_bank_pkg::PROG_MASK[$past(bus_addr)]) == 24'hffffff)
        else $error("fixed fuse bit read as zero");
    chk_swap_refused: assert property (
        s_swap_live ##0 cfg.boot_swap_instr_disable |=> boot_swap_refuse && !boot_swap_grant)
        else $error("boot swap not refused while disabled");
    chk_swap_granted: assert property (
        s_swap_live ##0 !cfg.boot_swap_instr_disable |=> boot_swap_grant && !boot_swap_refuse)
        else $error("boot swap not granted while enabled");
    chk_swap_early: assert property (
        s_swap_early |=> boot_swap_refuse && !boot_swap_grant)
        else $error("boot swap granted before shadows loaded");
    chk_swap_cause: assert property (
        boot_swap_grant || boot_swap_refuse |-> $past(boot_swap_req))
        else $error("boot swap answer without request");
    chk_release_bound: assert property (
        $rose(rst_n) |-> ##[1:12] units_release)
        else $error("shadows not released in time");
    chk_shadow_held: assert property (
        units_release |=> units_release && $stable(cfg))
        else $error("shadow configuration changed before reset");
    chk_safe_before: assert property (
        !units_release |-> cfg == '0)
        else $error("configuration driven before release");
    chk_selftest_por: assert property (
        selftest_start |-> $rose(units_release) && por_cause ##1 !selftest_start)
        else $error("self-test start outside power-on release");
    chk_pair_onehot: assert property (
        units_release |-> $onehot0(cfg.debug_pair_sel))
        else $error("more than one debug pin pair selected");
endmodule

bind device_config_fuse_bank fuse_bank_asserts fuse_bank_asserts_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .por_cause(por_cause), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .boot_swap_req(boot_swap_req),
    .boot_swap_grant(boot_swap_grant), .boot_swap_refuse(boot_swap_refuse),
    .units_release(units_release), .selftest_start(selftest_start), .cfg(cfg));
`default_nettype wire

// ### device_config_fuse_bank_tb_top.sv
// self-checking bench for the configuration fuse bank
// assumes the bench alone drives every input, erase included
`timescale 1ns/1ps
`default_nettype none
module device_config_fuse_bank_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic erase_n = 1'b0;
    logic por_cause = 1'b1;
    logic [3:0] bus_addr = 4'h0;
    logic [23:0] bus_wdata = 24'h000000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic boot_swap_req = 1'b0;
    logic [23:0] bus_rdata;
    logic boot_swap_grant;
    logic boot_swap_refuse;
    logic units_release;
    logic selftest_start;
    fuse_bank_pkg::cfg_out_t cfg;
    logic [23:0] fuse_m [7];
    int num_errors = 0;
    int cmp_count = 0;
    int st_seen = 0;

    device_config_fuse_bank device_config_fuse_bank_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .erase_n(erase_n), .por_cause(por_cause),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .boot_swap_req(boot_swap_req),
        .boot_swap_grant(boot_swap_grant), .boot_swap_refuse(boot_swap_refuse),
        .units_release(units_release), .selftest_start(selftest_start), .cfg(cfg));

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    // count self-test pulses; a double pulse shows up as two
    always @(posedge clk_sys) if (selftest_start === 1'b1) st_seen++;

    task automatic test_done();
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic report(input logic [69:0] got, input logic [69:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        report({46'h0, got}, {46'h0, exp});
    endtask

    task automatic chk_cfg(input fuse_bank_pkg::cfg_out_t got, input fuse_bank_pkg::cfg_out_t exp);
        report(got, exp);
    endtask

    // expected shadows, worked out from the model words
    function automatic fuse_bank_pkg::cfg_out_t exp_cfg();
        fuse_bank_pkg::cfg_out_t c;
        c.boot_swap_instr_disable = fuse_m[1][15];
        c.scan_port_enable = fuse_m[1][5];
        c.debug_pair_sel = fuse_m[1][1:0] == 2'h3 ? 3'h1 : fuse_m[1][1:0] == 2'h2 ? 3'h2 :
            fuse_m[1][1:0] == 2'h1 ? 3'h4 : 3'h0;
        c.deadman_enable = ~fuse_m[6][0];
        c.deadman_window_interval = {fuse_m[3][15:0], fuse_m[2][15:0]};
        c.deadman_instr_count_limit = {fuse_m[5][15:0], fuse_m[4][15:0]};
        return c;
    endfunction

    task automatic bus_write(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    task automatic read_chk(input logic [3:0] a, input logic [23:0] exp);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        @(negedge clk_sys);
        chk_word(bus_rdata, exp);
    endtask

    // program-once: zeros only ever clear bits inside the mask
    task automatic prog(input logic [3:0] a, input logic [23:0] d);
        bus_write(a, d);
        fuse_m[a] = fuse_m[a] & (d | ~fuse_bank_pkg::PROG_MASK[a]);
    endtask

    task automatic swap_chk(input logic refuse);
        @(posedge clk_sys);
        boot_swap_req <= 1'b1;
        @(posedge clk_sys);
        boot_swap_req <= 1'b0;
        @(negedge clk_sys);
        chk_word({23'h0, boot_swap_refuse}, {23'h0, refuse});
        chk_word({23'h0, boot_swap_grant}, {23'h0, ~refuse});
    endtask

    // reset with a given cause, then judge release, self-test and shadows
    task automatic restart(input logic por);
        int n;
        n = 0;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        por_cause <= por;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        st_seen = 0;
        swap_chk(1'b1);
        while (units_release !== 1'b1 && n < 12) begin
            @(negedge clk_sys);
            n++;
        end
        repeat (2) @(negedge clk_sys);
        chk_word({23'h0, units_release}, 24'h000001);
        chk_word(24'(st_seen), {23'h0, por & ~fuse_m[0][6]});
        chk_cfg(cfg, exp_cfg());
    endtask

    task automatic sc_erased();
        restart(1'b1);
        swap_chk(1'b1);
        for (int i = 0; i < 7; i++) read_chk(4'(i), fuse_m[i]);
        read_chk(4'h9, 24'h000000);
    endtask

    task automatic sc_program();
        fuse_bank_pkg::cfg_out_t held;
        held = exp_cfg();
        prog(4'h0, 24'h00ffbf);
        prog(4'h1, 24'h007ffe);
        prog(4'h2, 24'h001234);
        prog(4'h2, 24'h00ffff);
        prog(4'h3, 24'h005678);
        prog(4'h4, 24'h009abc);
        prog(4'h5, 24'h00def0);
        prog(4'h6, 24'h000000);
        for (int i = 0; i < 7; i++) read_chk(4'(i), fuse_m[i]);
        // shadows must still show the words loaded before programming
        chk_cfg(cfg, held);
        restart(1'b1);
        swap_chk(1'b0);
        restart(1'b0);
    endtask

    // a locked bank ignores programming until the next reset
    task automatic sc_lock();
        bus_write(fuse_bank_pkg::CONTROL_IDX, 24'h000001);
        bus_write(4'h4, 24'h000000);
        read_chk(4'h4, fuse_m[4]);
        read_chk(fuse_bank_pkg::CONTROL_IDX, 24'h000001);
        // loaded and lock set; last reset was warm, so no self-test and no power-on cause
        read_chk(fuse_bank_pkg::STATUS_IDX, 24'h000009);
    endtask

    // the third pin pair needs a fresh array, since codes only lose ones
    task automatic sc_third_pair();
        @(posedge clk_sys);
        erase_n <= 1'b0;
        @(posedge clk_sys);
        erase_n <= 1'b1;
        foreach (fuse_m[i]) fuse_m[i] = fuse_bank_pkg::ERASED_WORD;
        // the lock from the previous scenario only clears with a reset
        restart(1'b1);
        // scan port disabled beside the third pair, so both scan values are seen
        prog(4'h1, 24'h00ffdd);
        restart(1'b1);
    endtask

    initial begin
        foreach (fuse_m[i]) fuse_m[i] = fuse_bank_pkg::ERASED_WORD;
        repeat (2) @(posedge clk_sys);
        erase_n <= 1'b1;
        sc_erased();
        sc_program();
        sc_lock();
        sc_third_pair();
        test_done();
    end

    // the sequence needs well under 2000 cycles; 4000 means a hang
    initial begin
        #20000;
        num_errors++;
        test_done();
    end
endmodule
`default_nettype wire
